// file: sim/testbench.sv
// Self-checking bench for the operating watchdog.
// Assumes pclk is the crystal; bus calls wait for pready, never count on it.
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import wdt_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, rst_pin_oe, wrq, event_irq, rpo;
	sys_events_t sys;
	logic [7:0] vlow;
	logic hv_rst, hv_irq;
	int fail_count = 0;
	int n_tests = 0;

	// Short prescaler keeps the slow rate inside the run budget
	operating_watchdog #(.PRE_W(8), .CNT_W(6)) dut (.pclk(pclk),
		.presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys(sys), .reset_vector_low(vlow),
		.hv_reset_pin(hv_rst), .hv_irq_pin(hv_irq), .rst_pin_out(rpo),
		.rst_pin_oe(rst_pin_oe), .watchdog_reset_req(wrq),
		.event_irq(event_irq));

	// ****************************************
	// Clock, closing and helpers
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task stop_test;
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : stop_test

	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
			fail_count++;
		end
	endtask : chk

	task apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge keeps back-to-back calls from driving psel twice
		@(posedge pclk);
	endtask : apb

	task pulse(input int b);
		sys[b] <= 1'b1;
		@(posedge pclk);
		sys[b] <= 1'b0;
	endtask : pulse

	task irq_is(input logic e);
		@(negedge pclk);
		chk("event_irq", {31'h0, e}, {31'h0, event_irq});
		@(posedge pclk);
	endtask : irq_is

	// No reset pin activity for n cycles
	task quiet(input int n);
		int hits;
		hits = 0;
		repeat (n)
		begin
			@(negedge pclk);
			if (rst_pin_oe !== 1'b0)
				hits++;
		end
		chk("quiet", 0, hits);
		@(posedge pclk);
	endtask : quiet

	// Cycles to timeout within lo..hi, then one 32-cycle pulse
	task tmo(input int lo, input int hi);
		int n, w, q, d;
		n = 0;
		w = 0;
		q = 0;
		d = 0;
		while (rst_pin_oe !== 1'b1 && n <= hi)
		begin
			@(negedge pclk);
			n++;
		end
		chk("timeout window", 1, {31'h0, n >= lo && n <= hi});
		while (rst_pin_oe === 1'b1 && w < 100)
		begin
			w++;
			q += (wrq === 1'b1);
			d += (rpo !== 1'b0);
			@(negedge pclk);
		end
		chk("pulse length", RST_PULSE_CYCLES, w);
		chk("request pulses", 1, q);
		chk("pin level", 0, d);
		@(posedge pclk);
	endtask : tmo

	// ****************************************
	// Scenarios
	// ****************************************
	task t_regs;
		apb(0, OPTION_ADDR, 0);
		chk("option reset", 0, rd);
		apb(0, EV_ENABLE_ADDR, 0);
		chk("enable reset", 0, rd);
		apb(0, SERVICE_ADDR, 0);
		chk("service read", 32'h000000A5, rd);
		vlow <= 8'h3C;
		apb(0, SERVICE_ADDR, 0);
		chk("service read", 32'h0000003C, rd);
		apb(0, 18'h00100, 0);
		chk("unmapped err", 1, {31'h0, err});
		apb(1, OPTION_ADDR, 32'hFFFFFFFF);
		apb(0, OPTION_ADDR, 0);
		chk("option rw", 32'h7, rd);
		apb(1, OPTION_ADDR, 0);
		// Let the power-up prescaler clear pass first
		repeat (4200) @(posedge pclk);
		$display("regs done");
	endtask : t_regs

	task t_timeout;
		apb(1, EV_ENABLE_ADDR, 1);
		apb(1, SERVICE_ADDR, 32'h0);
		quiet(5000);
		apb(1, SERVICE_ADDR, 32'h5A);
		tmo(8170, 8200);
		apb(0, CAUSE_ADDR, 0);
		chk("cause flag", 1, rd & 32'h1);
		irq_is(1'b1);
		apb(1, EV_ENABLE_ADDR, 0);
		irq_is(1'b0);
		apb(1, EV_ENABLE_ADDR, 1);
		irq_is(1'b1);
		apb(1, EV_CLEAR_ADDR, 32'h7);
		irq_is(1'b0);
		apb(1, CAUSE_ADDR, 1);
		apb(0, CAUSE_ADDR, 0);
		chk("cause clear", 0, rd & 32'h1);
		$display("timeout done");
	endtask : t_timeout

	task t_modes;
		apb(1, OPTION_ADDR, 32'h2);
		apb(1, SERVICE_ADDR, 0);
		tmo(16360, 16400);
		apb(1, OPTION_ADDR, 0);
		apb(1, SERVICE_ADDR, 0);
		quiet(1000);
		// Mid-period prescaler, so a missed clear shows as an early reset
		pulse(0);
		repeat (64) @(posedge pclk);
		pulse(1);
		tmo(8170, 8200);
		apb(1, OPTION_ADDR, 1);
		apb(1, SERVICE_ADDR, 0);
		quiet(8300);
		apb(1, OPTION_ADDR, 0);
		$display("rates done");
	endtask : t_modes

	task t_test_voltage;
		sys.monitor_mode <= 1'b1;
		hv_irq <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1, SERVICE_ADDR, 0);
		quiet(8300);
		hv_irq <= 1'b0;
		tmo(8170, 8210);
		sys.monitor_mode <= 1'b0;
		sys.break_state <= 1'b1;
		hv_rst <= 1'b1;
		repeat (3) @(posedge pclk);
		apb(1, SERVICE_ADDR, 0);
		quiet(8300);
		hv_rst <= 1'b0;
		sys.break_state <= 1'b0;
		$display("test voltage done");
	endtask : t_test_voltage

	task t_stop;
		apb(1, EV_CLEAR_ADDR, 32'h7);
		pulse(3);
		apb(0, EV_STATUS_ADDR, 0);
		chk("stop ignored", 0, rd & 32'h4);
		apb(1, OPTION_ADDR, 32'h4);
		apb(1, SERVICE_ADDR, 0);
		pulse(3);
		apb(0, EV_STATUS_ADDR, 0);
		chk("stop taken", 32'h4, rd & 32'h4);
		quiet(8300);
		pulse(2);
		apb(1, SERVICE_ADDR, 0);
		tmo(8170, 8200);
		$display("stop done");
	endtask : t_stop

	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		sys = '0;
		vlow = 8'hA5;
		hv_rst = 1'b0;
		hv_irq = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_regs;
		t_timeout;
		t_modes;
		t_test_voltage;
		t_stop;
		stop_test;
	end

	initial
	begin
		#7000000;
		fail_count++;
		stop_test;
	end

endmodule : testbench

`default_nettype wire

// file: src/operating_watchdog.sv
// Operating watchdog: prescaler, 6-bit counter, reset pulse, APB registers.
// Assumes pclk is the crystal clock and system events are pclk pulses; monitor and break states are levels.
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module operating_watchdog
#(
	parameter int PRE_W = 12,
	parameter int CNT_W = 6
)
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [wdt_pkg::ADDR_W-1:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire wdt_pkg::sys_events_t sys,
	input wire logic [7:0] reset_vector_low,
	input wire logic hv_reset_pin,
	input wire logic hv_irq_pin,
	output logic rst_pin_out,
	output logic rst_pin_oe,
	output logic watchdog_reset_req,
	output logic event_irq
);
	import wdt_pkg::*;

	// Tap and counter widths the logic can serve
	if (PRE_W < RATE0_TAP + 1 || PRE_W > 24 || CNT_W < 1 || CNT_W > 16)
	begin : g_bad_width
		$error("operating_watchdog: unsupported widths");
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [1:0] hv_rst_q;
	logic [1:0] hv_irq_q;
	wire hv_rst = hv_rst_q[1];
	wire hv_irq = hv_irq_q[1];

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			hv_rst_q <= 2'b00;
			hv_irq_q <= 2'b00;
		end
		else
		begin
			hv_rst_q <= {hv_rst_q[0], hv_reset_pin};
			hv_irq_q <= {hv_irq_q[0], hv_irq_pin};
		end
	end

	// ****************************************
	// APB decode
	// ****************************************
	option_t option;
	logic cause_wdt;
	logic [EV_W-1:0] ev_status;
	logic [EV_W-1:0] ev_enable;

	wire setup = psel && !penable;
	wire access = psel && penable;
	wire hit_service = paddr == SERVICE_ADDR;
	wire hit_option = paddr == OPTION_ADDR;
	wire hit_cause = paddr == CAUSE_ADDR;
	wire hit_status = paddr == EV_STATUS_ADDR;
	wire hit_enable = paddr == EV_ENABLE_ADDR;
	wire hit_clear = paddr == EV_CLEAR_ADDR;
	wire mapped = hit_service || hit_option || hit_cause || hit_status
		|| hit_enable || hit_clear;
	wire wr = access && pwrite;
	wire service_wr = wr && hit_service;
	wire cause_wr = wr && hit_cause && pwdata[CAUSE_WDT_BIT];
	wire [EV_W-1:0] ev_clr = (wr && hit_clear) ? pwdata[EV_W-1:0] : '0;

	// Service read returns vector byte, no watchdog state
	wire [31:0] rd_mux =
		hit_service ? {24'h0, reset_vector_low} :
		hit_option ? {29'h0, option} :
		hit_cause ? {31'h0, cause_wdt} :
		hit_status ? {29'h0, ev_status} :
		hit_enable ? {29'h0, ev_enable} : 32'h0;

	assign pready = 1'b1;
	assign pslverr = access && !mapped;

	// Read data captured in setup so it is steady for the access phase
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			prdata <= 32'h0;
		else if (setup && !pwrite)
			prdata <= rd_mux;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			option <= OPTION_RESET;
			ev_enable <= EV_ENABLE_RESET;
		end
		else if (wr && hit_option)
			option <= pwdata[2:0];
		else if (wr && hit_enable)
			ev_enable <= pwdata[EV_W-1:0];
	end

	// ****************************************
	// Enable and mode control
	// ****************************************
	// Combinational on the synchronised pins, so dropping the test voltage re-enables two pclk edges later
	wire mon_block = sys.monitor_mode && (hv_rst || hv_irq);
	wire brk_block = sys.break_state && hv_rst;
	wire enabled = !option.disable_opt && !mon_block && !brk_block;

	wd_state_t state;
	wd_state_t next_state;
	logic [5:0] pulse_cnt;
	logic [PRE_W-1:0] pre;
	logic [CNT_W-1:0] cnt;
	logic [12:0] por_cnt;

	wire stop_take = sys.stop_instr && option.stop_enable;
	wire running = state == ST_RUN;
	// Wait mode is not an input: counting never pauses for it
	wire counting = enabled && running;
	wire tick = option.rate_select ? &pre : &pre[RATE0_TAP-1:0];
	wire wrap = counting && tick && &cnt;
	wire pulse_last = pulse_cnt == 6'(RST_PULSE_CYCLES - 1);
	wire por_hit = por_cnt == 13'(POR_CLEAR_CYCLES - 1);

	always_comb
	begin
		next_state = state;
		unique case (state)
			ST_RUN:
			begin
				if (wrap)
					next_state = ST_PULSE;
				else if (stop_take)
					next_state = ST_STOPPED;
			end
			ST_STOPPED:
			begin
				if (sys.wake)
					next_state = ST_RUN;
			end
			ST_PULSE:
			begin
				if (pulse_last)
					next_state = ST_RUN;
			end
			default:
				next_state = ST_RUN;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state <= ST_RUN;
		else
			state <= next_state;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pulse_cnt <= 6'h00;
		else if (state == ST_PULSE)
			pulse_cnt <= pulse_cnt + 6'h01;
		else
			pulse_cnt <= 6'h00;
	end

	// Power-up count runs once and then parks
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			por_cnt <= 13'h0000;
		else if (por_cnt != 13'(POR_CLEAR_CYCLES))
			por_cnt <= por_cnt + 13'h0001;
	end

	// ****************************************
	// Prescaler and counter
	// ****************************************
	wire pre_clear = !counting || stop_take || por_hit
		|| sys.vector_fetch || sys.internal_reset;
	wire [PRE_W-1:0] keep_mask = PRE_W'((1 << PRE_KEEP_BITS) - 1);

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pre <= '0;
		else if (pre_clear)
			pre <= '0;
		else if (service_wr)
			pre <= (pre & keep_mask) + PRE_W'(1);
		else
			pre <= pre + PRE_W'(1);
	end

	// Counter is held clear while disabled, so no reset can come
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			cnt <= '0;
		else if (!counting || sys.internal_reset || service_wr)
			cnt <= '0;
		else if (tick)
			cnt <= cnt + CNT_W'(1);
	end

	// ****************************************
	// Reset output and cause flag
	// ****************************************
	// Open-drain pin: only ever pulled low
	assign rst_pin_out = 1'b0;
	assign rst_pin_oe = state == ST_PULSE;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			watchdog_reset_req <= 1'b0;
			cause_wdt <= 1'b0;
		end
		else
		begin
			watchdog_reset_req <= wrap;
			if (wrap)
				cause_wdt <= 1'b1;
			else if (cause_wr)
				cause_wdt <= 1'b0;
		end
	end

	// ****************************************
	// Event status and monitor line
	// ****************************************
	wire [EV_W-1:0] ev_set = {stop_take && running, service_wr, wrap};

	// Set wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			ev_status <= '0;
		else
			ev_status <= (ev_status & ~ev_clr) | ev_set;
	end

	// System event line only, never a processor interrupt request
	assign event_irq = |(ev_status & ev_enable);

	// ****************************************
	// Checks
	// ****************************************
	logic [6:0] oe_len;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			oe_len <= 7'h00;
		else if (rst_pin_oe)
			oe_len <= oe_len + 7'h01;
		else
			oe_len <= 7'h00;
	end

	chk_service_clears: assert property (
		@(posedge pclk) disable iff (!presetn)
		service_wr |=> cnt == '0 && ($past(pre_clear) ? pre == '0
		: pre == ($past(pre) & keep_mask) + PRE_W'(1)))
		else $error("service write did not clear counter");
	chk_read_vector: assert property (
		@(posedge pclk) disable iff (!presetn)
		setup && !pwrite && hit_service
		|=> prdata == {24'h0, $past(reset_vector_low)})
		else $error("service read not vector low byte");
	chk_pulse_len: assert property (
		@(posedge pclk) disable iff (!presetn)
		$fell(rst_pin_oe) |-> oe_len == 7'(RST_PULSE_CYCLES))
		else $error("reset pulse length wrong");
	chk_wrap_reset: assert property (
		@(posedge pclk) disable iff (!presetn)
		wrap |=> rst_pin_oe && watchdog_reset_req && cause_wdt)
		else $error("timeout did not reset");
	chk_cause_sticky: assert property (
		@(posedge pclk) disable iff (!presetn)
		cause_wdt && !cause_wr |=> cause_wdt)
		else $error("watchdog cause flag lost");
	chk_monitor_hv: assert property (
		@(posedge pclk) disable iff (!presetn)
		sys.monitor_mode && hv_irq |=> cnt == '0 || !$past(sys.monitor_mode))
		else $error("monitor voltage did not disable");
	chk_monitor_release: assert property (
		@(posedge pclk) disable iff (!presetn)
		sys.monitor_mode && !hv_rst && !hv_irq && !brk_block
		&& !option.disable_opt && running |-> counting)
		else $error("monitor release did not enable");
	chk_break_hv: assert property (
		@(posedge pclk) disable iff (!presetn)
		sys.break_state && hv_rst |-> !wrap ##1 cnt == '0)
		else $error("break voltage did not disable");
	chk_stop_halt: assert property (
		@(posedge pclk) disable iff (!presetn)
		stop_take && running && !wrap |=> state == ST_STOPPED && pre == '0)
		else $error("stop did not halt watchdog");
	chk_stop_gated: assert property (
		@(posedge pclk) disable iff (!presetn)
		sys.stop_instr && !option.stop_enable && running && !wrap
		|=> state == ST_RUN)
		else $error("stop taken while not enabled");
	chk_internal_rst: assert property (
		@(posedge pclk) disable iff (!presetn)
		sys.internal_reset |=> cnt == '0 && pre == '0)
		else $error("internal reset did not clear");
	chk_por_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		por_hit |=> pre == '0)
		else $error("power-up clear missed");
	chk_vector_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		sys.vector_fetch |=> pre == '0)
		else $error("vector fetch did not clear prescaler");
	chk_disabled_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		option.disable_opt && running |=> cnt == '0 && !rst_pin_oe)
		else $error("disabled watchdog counted");
	chk_request_once: assert property (
		@(posedge pclk) disable iff (!presetn)
		watchdog_reset_req |=> !watchdog_reset_req)
		else $error("reset request longer than one cycle");
	chk_tick_rate: assert property (
		@(posedge pclk) disable iff (!presetn)
		counting && !option.rate_select && !tick && !service_wr
		&& !pre_clear |=> $stable(cnt))
		else $error("counter advanced off tick");
	chk_rate1_tick: assert property (
		@(posedge pclk) disable iff (!presetn)
		counting && option.rate_select && !tick && !service_wr
		&& !pre_clear |=> $stable(cnt))
		else $error("slow rate counter advanced off tick");

	// ****************************************
	// Scenario covers
	// ****************************************
	cov_timeout: cover property (@(posedge pclk) disable iff (!presetn)
		wrap ##1 rst_pin_oe);
	cov_stop_wake: cover property (@(posedge pclk) disable iff (!presetn)
		state == ST_STOPPED ##1 sys.wake);
	cov_service: cover property (@(posedge pclk) disable iff (!presetn)
		service_wr && cnt != '0);
	cov_rate_slow: cover property (@(posedge pclk) disable iff (!presetn)
		wrap && option.rate_select);
	cov_monitor_release: cover property (@(posedge pclk) disable iff (!presetn)
		$fell(mon_block) ##1 counting);

endmodule : operating_watchdog

`default_nettype wire

// file: src/wdt_pkg.sv
// Constants, register map and carrier types for the operating watchdog.
// Assumes a 32-bit APB slave with byte addressing and word registers.
package wdt_pkg;

	// ****************************************
	// Register map: index, then byte address
	// ****************************************
	localparam int ADDR_W = 18;
	localparam logic [15:0] SERVICE_IDX = 16'hFFFF;
	localparam logic [15:0] OPTION_IDX = 16'h0000;
	localparam logic [15:0] CAUSE_IDX = 16'h0001;
	localparam logic [15:0] EV_STATUS_IDX = 16'h0002;
	localparam logic [15:0] EV_ENABLE_IDX = 16'h0003;
	localparam logic [15:0] EV_CLEAR_IDX = 16'h0004;
	localparam logic [17:0] SERVICE_ADDR = {SERVICE_IDX, 2'b00};
	localparam logic [17:0] OPTION_ADDR = {OPTION_IDX, 2'b00};
	localparam logic [17:0] CAUSE_ADDR = {CAUSE_IDX, 2'b00};
	localparam logic [17:0] EV_STATUS_ADDR = {EV_STATUS_IDX, 2'b00};
	localparam logic [17:0] EV_ENABLE_ADDR = {EV_ENABLE_IDX, 2'b00};
	localparam logic [17:0] EV_CLEAR_ADDR = {EV_CLEAR_IDX, 2'b00};

	// ****************************************
	// Fields and reset values
	// ****************************************
	localparam int EV_W = 3;
	localparam int EV_TIMEOUT_BIT = 0;
	localparam int EV_SERVICE_BIT = 1;
	localparam int EV_STOP_BIT = 2;
	localparam int CAUSE_WDT_BIT = 0;
	localparam logic [2:0] OPTION_RESET = 3'h0;
	localparam logic [EV_W-1:0] EV_ENABLE_RESET = 3'h0;

	// ****************************************
	// Timing: prescaler bits, then lengths in crystal clock cycles
	// ****************************************
	localparam int PRE_KEEP_BITS = 4;
	localparam int RATE0_TAP = 7;
	localparam int RST_PULSE_CYCLES = 32;
	localparam int POR_CLEAR_CYCLES = 4096;

	typedef struct packed
	{
		logic stop_enable;
		logic rate_select;
		logic disable_opt;
	} option_t;

	typedef struct packed
	{
		logic monitor_mode;
		logic break_state;
		logic stop_instr;
		logic wake;
		logic vector_fetch;
		logic internal_reset;
	} sys_events_t;

	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_STOPPED = 2'b01,
		ST_PULSE = 2'b10
	} wd_state_t;

endpackage : wdt_pkg
